// [dma_channel_status_control.sv]
// Control and status logic of one DMA channel: start, active, done,
// major-loop linking, scatter/gather reload, request disable, interrupts.
// Assumes minor-loop byte counting and addressing sit outside and report
// each finished minor loop and each transfer error as one-cycle pulses.
`timescale 1ns/100ps
`default_nettype none
module dma_channel_status_control
  import dma_ch_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Avalon-MM register slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Transfer engine side
  input wire logic hw_req,
  input wire logic minor_done,
  input wire logic xfer_error,
  output logic channel_active,
  output logic hw_request_enable_bit,
  // Channel linking
  input wire logic link_start_in,
  output logic link_start_out,
  output logic [LINKCH_W-1:0] link_ch_out,
  // Descriptor fetch master
  output logic fetch_req,
  output logic [31:0] fetch_addr,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_data,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ctrl_t ctrl_q, ctrl_d;
  logic [COUNT_W-1:0] citer_q, citer_d;
  logic [31:0] sga_q, sga_d;
  logic [31:0] daddr_q, daddr_d;
  logic [IRQ_W-1:0] stat_q, stat_d;
  logic [IRQ_W-1:0] mask_q, mask_d;
  logic reqen_q, reqen_d;
  logic link_q, link_d;
  logic [LINKCH_W-1:0] link_ch_q, link_ch_d;
  logic fetch_req_q, fetch_req_d;
  logic [DESC_IDX_W-1:0] fidx_q, fidx_d;
  logic half_seen_q, half_seen_d;
  logic irq_q, irq_d;
  eng_state_t st_q, st_d;
  bus_state_t bst_q, bst_d;
  logic [31:0] rdata_q, rdata_d;
  logic wait_q, wait_d;
  logic [31:0] mem_rdata;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic wr_take;
  logic in_desc;
  logic [DESC_IDX_W-1:0] desc_idx;

  // A write takes effect only on the edge where waitrequest is low
  assign wr_take = avs_write && (bst_q == BUS_DONE);
  assign in_desc = (avs_address >= DESC_BASE_OFS);
  assign desc_idx = avs_address[2 +: DESC_IDX_W];
  desc_mem #(
    .DEPTH(DESC_WORDS),
    .IDX_W(DESC_IDX_W),
    .DATA_W(32)
  ) u_desc_mem (
    .clk_sys(clk_sys),
    .wr_en(fetch_req_q && fetch_valid),
    .wr_idx(fidx_q),
    .wr_data(fetch_data),
    .rd_idx(desc_idx),
    .rd_data(mem_rdata)
  );

  // ----------------------------------------------------------------
  // Bus handshake: two wait states so descriptor reads come from a flop
  // ----------------------------------------------------------------
  always_comb begin
    bst_d = bst_q;
    wait_d = wait_q;
    rdata_d = rdata_q;
    case (bst_q)
      BUS_IDLE: bst_d = (avs_read || avs_write) ? BUS_PREP : BUS_IDLE;
      BUS_PREP: begin
        bst_d = BUS_DONE;
        wait_d = 1'b0;
        rdata_d = 32'h00000000;
        if (avs_read) begin
          if (in_desc) begin
            rdata_d = mem_rdata;
          end else begin
            case (avs_address)
              CTRL_OFS: rdata_d = ctrl_to_word(ctrl_q);
              CITER_OFS: rdata_d = {{(32-COUNT_W){1'b0}}, citer_q};
              SGA_OFS: rdata_d = sga_q;
              DADDR_OFS: rdata_d = daddr_q;
              IRQ_STAT_OFS: rdata_d = {{(32-IRQ_W){1'b0}}, stat_q};
              IRQ_MASK_OFS: rdata_d = {{(32-IRQ_W){1'b0}}, mask_q};
              REQEN_OFS: rdata_d = {31'h00000000, reqen_q};
              default: rdata_d = 32'h00000000;
            endcase
          end
        end
      end
      BUS_DONE: begin
        bst_d = BUS_IDLE;
        wait_d = 1'b1;
      end
      default: begin
        bst_d = BUS_IDLE;
        wait_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bst_q <= BUS_IDLE;
      wait_q <= 1'b1;
      rdata_q <= WORD_RST;
    end else begin
      bst_q <= bst_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Channel engine and registers
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] wv;
    ctrl_t wc;
    logic [COUNT_W-1:0] cnext;
    logic done_set;
    logic [IRQ_W-1:0] ev;
    logic [31:0] sw_ctrl;
    wv = 32'h00000000;
    wc = word_to_ctrl(CTRL_RST);
    cnext = citer_q;
    done_set = 1'b0;
    ev = IRQ_RST;
    sw_ctrl = ctrl_to_word(ctrl_q);
    ctrl_d = ctrl_q;
    citer_d = citer_q;
    sga_d = sga_q;
    daddr_d = daddr_q;
    mask_d = mask_q;
    reqen_d = reqen_q;
    link_d = 1'b0;
    link_ch_d = link_ch_q;
    fetch_req_d = fetch_req_q;
    fidx_d = fidx_q;
    half_seen_d = half_seen_q;
    st_d = st_q;
    // Software writes first; engine events below override them
    if (wr_take && !in_desc) begin
      case (avs_address)
        CTRL_OFS: begin
          wv = merge_be(sw_ctrl, avs_writedata, avs_byteenable);
          wc = word_to_ctrl(wv);
          ctrl_d.biter = wc.biter;
          ctrl_d.linkch = wc.linkch;
          ctrl_d.dis_req = wc.dis_req;
          ctrl_d.int_half = wc.int_half;
          ctrl_d.int_maj = wc.int_maj;
          ctrl_d.start = ctrl_q.start | wc.start;
          ctrl_d.done = ctrl_q.done & wc.done;
          if (!ctrl_q.done) begin
            ctrl_d.major_link = wc.major_link;
            ctrl_d.sg_en = wc.sg_en;
          end
        end
        CITER_OFS: begin
          wv = merge_be({{(32-COUNT_W){1'b0}}, citer_q}, avs_writedata,
                        avs_byteenable);
          citer_d = wv[COUNT_W-1:0];
          half_seen_d = 1'b0;
        end
        SGA_OFS: sga_d = merge_be(sga_q, avs_writedata, avs_byteenable);
        DADDR_OFS: daddr_d = merge_be(daddr_q, avs_writedata, avs_byteenable);
        IRQ_MASK_OFS: begin
          wv = merge_be({{(32-IRQ_W){1'b0}}, mask_q}, avs_writedata,
                        avs_byteenable);
          mask_d = wv[IRQ_W-1:0];
        end
        REQEN_OFS: reqen_d = avs_byteenable[0] ? avs_writedata[0] : reqen_q;
        default: ;
      endcase
    end

    // Another channel's major link sets this channel's start
    ctrl_d.start = ctrl_d.start | link_start_in;
    case (st_q)
      ST_IDLE: begin
        // Service begins on an explicit start or an enabled request
        if ((ctrl_q.start || (hw_req && reqen_q)) && citer_q != '0) begin
          ctrl_d.active = 1'b1;
          ctrl_d.start = 1'b0;
          ctrl_d.done = 1'b0;
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (xfer_error) begin
          ctrl_d.active = 1'b0;
          st_d = ST_IDLE;
        end else if (minor_done) begin
          ctrl_d.active = 1'b0;
          cnext = citer_q - 1'b1;
          citer_d = cnext;
          st_d = ST_IDLE;
          // Biter of one has no half point distinct from the end
          if (ctrl_q.int_half && !half_seen_q && cnext != '0 &&
              cnext == (ctrl_q.biter >> 1)) begin
            ev[IRQ_HALF] = 1'b1;
            half_seen_d = 1'b1;
          end
          if (cnext == '0) begin
            done_set = 1'b1;
            citer_d = ctrl_q.biter;
            half_seen_d = 1'b0;
            ev[IRQ_MAJ] = ctrl_q.int_maj;
            reqen_d = reqen_d & ~ctrl_q.dis_req;
            if (ctrl_q.major_link) begin
              link_d = 1'b1;
              link_ch_d = ctrl_q.linkch;
            end
            if (ctrl_q.sg_en) begin
              if ((sga_q & SG_ALIGN_MASK) != 32'h00000000) begin
                ev[IRQ_CFG_ERR] = 1'b1;
              end else begin
                fetch_req_d = 1'b1;
                fidx_d = '0;
                st_d = ST_FETCH;
              end
            end else begin
              daddr_d = daddr_q + sga_q;
            end
          end
        end
      end
      ST_FETCH: begin
        // Words land in the store in order; control words are applied
        if (fetch_valid) begin
          daddr_d = (fidx_q == DESC_DADDR_IDX) ? fetch_data : daddr_d;
          sga_d = (fidx_q == DESC_SGA_IDX) ? fetch_data : sga_d;
          if (fidx_q == DESC_CTRL_IDX) begin
            wc = word_to_ctrl(fetch_data);
            ctrl_d = wc;
            ctrl_d.start = wc.start | ctrl_q.start | link_start_in;
            ctrl_d.active = 1'b0;
            ctrl_d.done = 1'b1;
            citer_d = wc.biter;
            fetch_req_d = 1'b0;
            st_d = ST_IDLE;
          end
          fidx_d = fidx_q + 1'b1;
        end
      end
      default: begin
        st_d = ST_IDLE;
        ctrl_d.active = 1'b0;
        fetch_req_d = 1'b0;
      end
    endcase

    // Hardware set of done wins over a software clear in the same cycle
    ctrl_d.done = ctrl_d.done | done_set;
    ev[IRQ_CFG_ERR] = ev[IRQ_CFG_ERR] | (xfer_error && st_q == ST_RUN);
    // Sticky status, write one to clear, set beats clear
    stat_d = stat_q;
    if (wr_take && avs_address == IRQ_STAT_OFS && avs_byteenable[0]) begin
      stat_d = stat_q & ~avs_writedata[IRQ_W-1:0];
    end
    stat_d = stat_d | ev;
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= word_to_ctrl(CTRL_RST);
      citer_q <= '0;
      sga_q <= WORD_RST;
      daddr_q <= WORD_RST;
      stat_q <= IRQ_RST;
      mask_q <= IRQ_RST;
      reqen_q <= REQEN_RST;
      link_q <= 1'b0;
      link_ch_q <= '0;
      fetch_req_q <= 1'b0;
      fidx_q <= '0;
      half_seen_q <= 1'b0;
      irq_q <= 1'b0;
      st_q <= ST_IDLE;
    end else begin
      ctrl_q <= ctrl_d;
      citer_q <= citer_d;
      sga_q <= sga_d;
      daddr_q <= daddr_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      reqen_q <= reqen_d;
      link_q <= link_d;
      link_ch_q <= link_ch_d;
      fetch_req_q <= fetch_req_d;
      fidx_q <= fidx_d;
      half_seen_q <= half_seen_d;
      irq_q <= irq_d;
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flops
  // ----------------------------------------------------------------
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign channel_active = ctrl_q.active;
  assign hw_request_enable_bit = reqen_q;
  assign link_start_out = link_q;
  assign link_ch_out = link_ch_q;
  assign fetch_req = fetch_req_q;
  // Word address walks the 32-byte block at sga_q; word 7 uses the sga word fetched as word 6
  assign fetch_addr = {sga_q[31:5], fidx_q, 2'b00};
  assign irq = irq_q;

endmodule : dma_channel_status_control
`default_nettype wire

// [dma_ch_pkg.sv]
// Shared constants, field layouts and types of the DMA channel control block.
// Assumes a single 50 MHz system clock and one Avalon-MM register slave.
package dma_ch_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] CITER_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] SGA_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] DADDR_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] REQEN_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] DESC_BASE_OFS = 8'h20;

  // ----------------------------------------------------------------
  // Control/status word layout
  // ----------------------------------------------------------------
  localparam int COUNT_W = 15;
  localparam int LINKCH_W = 5;
  localparam int START_BIT = 0;
  localparam int INT_MAJ_BIT = 1;
  localparam int INT_HALF_BIT = 2;
  localparam int DIS_REQ_BIT = 3;
  localparam int SG_EN_BIT = 4;
  localparam int MAJOR_LINK_BIT = 5;
  localparam int ACTIVE_BIT = 6;
  localparam int DONE_BIT = 7;
  localparam int LINKCH_LSB = 8;
  localparam int BITER_LSB = 16;

  // Interrupt status / mask bits
  localparam int IRQ_W = 3;
  localparam int IRQ_MAJ = 0;
  localparam int IRQ_HALF = 1;
  localparam int IRQ_CFG_ERR = 2;

  // Descriptor structure: eight words, 0-modulo-32 aligned
  localparam int DESC_WORDS = 8;
  localparam int DESC_IDX_W = 3;
  localparam logic [31:0] SG_ALIGN_MASK = 32'h0000001f;
  localparam logic [DESC_IDX_W-1:0] DESC_DADDR_IDX = 3'h4;
  localparam logic [DESC_IDX_W-1:0] DESC_SGA_IDX = 3'h6;
  localparam logic [DESC_IDX_W-1:0] DESC_CTRL_IDX = 3'h7;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [31:0] WORD_RST = 32'h00000000;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
  localparam logic REQEN_RST = 1'b0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [COUNT_W-1:0] biter;
    logic [LINKCH_W-1:0] linkch;
    logic done;
    logic active;
    logic major_link;
    logic sg_en;
    logic dis_req;
    logic int_half;
    logic int_maj;
    logic start;
  } ctrl_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_FETCH = 3'b100
  } eng_state_t;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_PREP = 3'b010,
    BUS_DONE = 3'b100
  } bus_state_t;

  function automatic logic [31:0] ctrl_to_word(input ctrl_t c);
    logic [31:0] w;
    w = 32'h00000000;
    w[BITER_LSB +: COUNT_W] = c.biter;
    w[LINKCH_LSB +: LINKCH_W] = c.linkch;
    w[DONE_BIT] = c.done;
    w[ACTIVE_BIT] = c.active;
    w[MAJOR_LINK_BIT] = c.major_link;
    w[SG_EN_BIT] = c.sg_en;
    w[DIS_REQ_BIT] = c.dis_req;
    w[INT_HALF_BIT] = c.int_half;
    w[INT_MAJ_BIT] = c.int_maj;
    w[START_BIT] = c.start;
    return w;
  endfunction : ctrl_to_word

  function automatic ctrl_t word_to_ctrl(input logic [31:0] w);
    ctrl_t c;
    c.biter = w[BITER_LSB +: COUNT_W];
    c.linkch = w[LINKCH_LSB +: LINKCH_W];
    c.done = w[DONE_BIT];
    c.active = w[ACTIVE_BIT];
    c.major_link = w[MAJOR_LINK_BIT];
    c.sg_en = w[SG_EN_BIT];
    c.dis_req = w[DIS_REQ_BIT];
    c.int_half = w[INT_HALF_BIT];
    c.int_maj = w[INT_MAJ_BIT];
    c.start = w[START_BIT];
    return c;
  endfunction : word_to_ctrl

  // Byte-enable merge of a bus write into an old register value
  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction : merge_be

endpackage : dma_ch_pkg

// [desc_mem.sv]
// Eight-word store for the last fetched transfer descriptor.
// Assumes one writer and one reader; read data is registered.
`timescale 1ns/100ps
`default_nettype none
module desc_mem #(
  parameter int DEPTH = 8,
  parameter int IDX_W = 3,
  parameter int DATA_W = 32
) (
  // Clock
  input wire logic clk_sys,
  // Write port
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [DATA_W-1:0] wr_data,
  // Read port
  input wire logic [IDX_W-1:0] rd_idx,
  output logic [DATA_W-1:0] rd_data
);

  logic [DATA_W-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    rd_data <= mem[rd_idx];
  end

endmodule : desc_mem
`default_nettype wire

// [dma_csc_chk.sv]
// Port-level checks for the DMA channel control block.
// Bound to every instance of the block; one clock, synchronous reset.
`timescale 1ns/100ps
`default_nettype none
module dma_csc_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Inputs watched, and the avs_waitrequest output
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic minor_done,
  input wire logic xfer_error,
  input wire logic fetch_valid,
  // Outputs watched
  input wire logic channel_active,
  input wire logic hw_request_enable_bit,
  input wire logic link_start_out,
  input wire logic fetch_req,
  input wire logic [31:0] fetch_addr,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [2:0] since_q, since_d;
  logic busy_q, busy_d;
  // Ages saturate so a late fetch start cannot wrap back into range
  always_comb begin
    since_d = minor_done ? 3'h0 : (since_q == 3'h7 ? 3'h7 : since_q + 3'h1);
    busy_d = busy_q;
    if (fetch_req) busy_d = 1'b1;
    if (fetch_valid && fetch_addr[4:2] == 3'h7) busy_d = 1'b0;
  end
  always_ff @(posedge clk_sys) begin
    since_q <= rst ? 3'h7 : since_d;
    busy_q <= rst ? 1'b0 : busy_d;
  end
  a_link_single: assert property (link_start_out |=> !link_start_out)
    else $error("link pulse longer than one cycle");
  a_link_cause: assert property (
    link_start_out |-> $past(minor_done && channel_active))
    else $error("link pulse without loop completion");
  a_active_minor: assert property (
    channel_active && minor_done |=> !channel_active)
    else $error("active kept after minor loop end");
  a_active_error: assert property (
    channel_active && xfer_error |=> !channel_active)
    else $error("active kept after transfer error");
  a_reqen_clear: assert property (
    $fell(hw_request_enable_bit) |-> $past(minor_done && channel_active) ||
    $past(avs_write && !avs_waitrequest))
    else $error("request enable dropped without cause");
  a_fetch_hold: assert property (
    fetch_req && !fetch_valid |=> fetch_req && $stable(fetch_addr))
    else $error("fetch request not held");
  a_fetch_first: assert property (
    fetch_req && !busy_q |-> fetch_addr[4:0] == 5'h00)
    else $error("fetch does not begin at word zero");
  a_fetch_cause: assert property (
    fetch_req && !busy_q |-> since_q <= 3'h3)
    else $error("fetch started without loop completion");
  c_link: cover property (link_start_out);
  c_fetch: cover property (fetch_req && !busy_q);
  c_irq: cover property ($rose(irq));
endmodule : dma_csc_chk
bind dma_channel_status_control dma_csc_chk i_chk (
  .clk_sys(clk_sys), .rst(rst), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .minor_done(minor_done),
  .xfer_error(xfer_error), .fetch_valid(fetch_valid),
  .channel_active(channel_active), .irq(irq),
  .hw_request_enable_bit(hw_request_enable_bit),
  .link_start_out(link_start_out), .fetch_req(fetch_req),
  .fetch_addr(fetch_addr));
`default_nettype wire

// [dma_desc_mem_model.sv]
// Descriptor memory seen by the channel's fetch master.
// Answers each held word request after LAT+1 idle cycles.
`timescale 1ns/100ps
`default_nettype none
module dma_desc_mem_model #(
  parameter int LAT = 2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Fetch port
  input wire logic fetch_req,
  input wire logic [31:0] fetch_addr,
  output logic fetch_valid,
  output logic [31:0] fetch_data
);
  int wait_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wait_q <= 0;
      fetch_valid <= 1'b0;
      fetch_data <= 32'h0;
    end else begin
      fetch_valid <= 1'b0;
      // Outside a valid beat the data lines keep toggling
      fetch_data <= ~fetch_data;
      if (fetch_req && !fetch_valid) begin
        wait_q <= (wait_q == LAT) ? 0 : wait_q + 1;
        if (wait_q == LAT) begin
          fetch_valid <= 1'b1;
          case (fetch_addr[4:2])
            3'h4: fetch_data <= 32'h00005000;
            3'h6: fetch_data <= 32'h00000080;
            3'h7: fetch_data <= 32'h00030000;
            default: fetch_data <= fetch_addr;
          endcase
        end
      end
    end
  end
endmodule : dma_desc_mem_model
`default_nettype wire

// [dma_channel_status_control_tb.sv]
// Self-checking bench for the DMA channel control block.
// Drives the register bus, engine pulses and a descriptor memory model.
`timescale 1ns/100ps
`default_nettype none
module dma_channel_status_control_tb;
  import dma_ch_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hf;
  logic hw_req = 1'b0;
  logic minor_done = 1'b0;
  logic xfer_error = 1'b0;
  logic link_start_in = 1'b0;
  logic [31:0] avs_readdata, fetch_addr, fetch_data;
  logic avs_waitrequest, channel_active, hw_request_enable_bit, irq;
  logic link_start_out, fetch_req, fetch_valid;
  logic [LINKCH_W-1:0] link_ch_out, link_ch_seen;
  int n_fail = 0;
  int samples_checked = 0;
  int n_link = 0;
  always #10 clk_sys = ~clk_sys;
  dma_channel_status_control i_dut (.clk_sys(clk_sys), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .hw_req(hw_req), .minor_done(minor_done), .xfer_error(xfer_error),
    .channel_active(channel_active), .irq(irq),
    .hw_request_enable_bit(hw_request_enable_bit),
    .link_start_in(link_start_in), .link_start_out(link_start_out),
    .link_ch_out(link_ch_out), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
    .fetch_data(fetch_data));
  dma_desc_mem_model i_mem (.clk_sys(clk_sys), .rst(rst),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_valid(fetch_valid), .fetch_data(fetch_data));
  always @(posedge clk_sys) begin
    if (link_start_out === 1'b1) begin
      n_link++;
      link_ch_seen = link_ch_out;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd_chk
  task automatic wait_act();
    for (int i = 0; i < 40 && channel_active !== 1'b1; i++) @(posedge clk_sys);
    // A start that never comes counts as a mismatch
    chk(channel_active, 1'b1);
  endtask : wait_act
  // One-cycle minor loop end or error, then let the flags settle
  task automatic end_loop(input logic err);
    @(posedge clk_sys);
    minor_done <= ~err;
    xfer_error <= err;
    @(posedge clk_sys);
    minor_done <= 1'b0;
    xfer_error <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : end_loop
  task automatic conclude();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (4000) @(posedge clk_sys);
    n_fail++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(CTRL_OFS, CTRL_RST);
    wr(REQEN_OFS, 32'h1);
    wr(IRQ_MASK_OFS, 32'h7);
    wr(CITER_OFS, 32'h2);
    wr(CTRL_OFS, 32'h00020527);
    wait_act();
    chk(channel_active, 1'b1);
    rd_chk(CTRL_OFS, 32'h00020566);
    end_loop(1'b0);
    chk(channel_active, 1'b0);
    chk(irq, 1'b1);
    rd_chk(IRQ_STAT_OFS, 32'h2);
    wr(IRQ_STAT_OFS, 32'h2);
    rd_chk(IRQ_STAT_OFS, 32'h0);
    wr(CTRL_OFS, 32'h00020527);
    wait_act();
    end_loop(1'b0);
    chk(n_link, 1);
    chk(link_ch_seen, 5'h05);
    rd_chk(CITER_OFS, 32'h2);
    rd_chk(CTRL_OFS, 32'h000205a6);
    rd_chk(IRQ_STAT_OFS, 32'h1);
    chk(irq, 1'b1);
    rd_chk(REQEN_OFS, 32'h1);
    // Link enable may not change while done is still set
    wr(CTRL_OFS, 32'h00020586);
    rd_chk(CTRL_OFS, 32'h000205a6);
    wr(CTRL_OFS, 32'h00020506);
    wr(CTRL_OFS, 32'h00010008);
    rd_chk(CTRL_OFS, 32'h00010008);
    wr(IRQ_STAT_OFS, 32'h7);
    wr(DADDR_OFS, 32'h100);
    wr(SGA_OFS, 32'h20);
    wr(CITER_OFS, 32'h1);
    hw_req <= 1'b1;
    wait_act();
    hw_req <= 1'b0;
    chk(channel_active, 1'b1);
    end_loop(1'b0);
    chk(n_link, 1);
    chk(irq, 1'b0);
    rd_chk(REQEN_OFS, 32'h0);
    rd_chk(DADDR_OFS, 32'h120);
    rd_chk(CTRL_OFS, 32'h00010088);
    wr(REQEN_OFS, 32'h1);
    hw_req <= 1'b1;
    wait_act();
    hw_req <= 1'b0;
    rd_chk(CTRL_OFS, 32'h00010048);
    end_loop(1'b1);
    chk(channel_active, 1'b0);
    rd_chk(IRQ_STAT_OFS, 32'h4);
    wr(IRQ_STAT_OFS, 32'h7);
    wr(CTRL_OFS, 32'h00010000);
    link_start_in <= 1'b1;
    @(posedge clk_sys);
    link_start_in <= 1'b0;
    wait_act();
    chk(channel_active, 1'b1);
    end_loop(1'b0);
    rd_chk(REQEN_OFS, 32'h1);
    // Misaligned descriptor pointer: error, no fetch
    wr(SGA_OFS, 32'h24);
    wr(CTRL_OFS, 32'h00010000);
    wr(CTRL_OFS, 32'h00010011);
    wait_act();
    end_loop(1'b0);
    chk(fetch_req, 1'b0);
    rd_chk(IRQ_STAT_OFS, 32'h4);
    rd_chk(CTRL_OFS, 32'h00010090);
    wr(IRQ_STAT_OFS, 32'h7);
    wr(SGA_OFS, 32'h40);
    wr(CTRL_OFS, 32'h00010010);
    wr(CTRL_OFS, 32'h00010011);
    wait_act();
    end_loop(1'b0);
    for (int i = 0; i < 200 && fetch_req === 1'b1; i++) @(posedge clk_sys);
    chk(fetch_req, 1'b0);
    rd_chk(DADDR_OFS, 32'h5000);
    rd_chk(SGA_OFS, 32'h80);
    rd_chk(CITER_OFS, 32'h3);
    rd_chk(CTRL_OFS, 32'h00030080);
    rd_chk(DESC_BASE_OFS, 32'h40);
    rd_chk(DESC_BASE_OFS + 8'h1c, 32'h00030000);
    wr(DESC_BASE_OFS, 32'h1);
    rd_chk(DESC_BASE_OFS, 32'h40);
    wr(8'h1c, 32'hffffffff);
    rd_chk(8'h1c, 32'h0);
    conclude();
  end
endmodule : dma_channel_status_control_tb
`default_nettype wire
